//--- design/cfp_map.vh
// Constants for the converter fault protection block
`ifndef CFP_MAP_VH
`define CFP_MAP_VH
`define CFP_ADDR_STATUS 8'h16
`define CFP_ADDR_CONFIG_ONE 8'h15
`define CFP_ADDR_CONFIG_TWO 8'h17
`define CFP_ADDR_PROPAGATE 8'h18
`define CFP_CONFIG_ONE_RESET 8'h43
`define CFP_CONFIG_TWO_RESET 8'h08
`define CFP_PROPAGATE_RESET 8'h00
`define CFP_BIT_TEMP_WARN 7
`define CFP_BIT_POWER_OK 6
`define CFP_BIT_RAMP 5
`define CFP_BIT_HEAT 4
`define CFP_BIT_CURRENT 3
`define CFP_BIT_LOW_V 2
`define CFP_BIT_HIGH_V 1
`define CFP_BIT_PHASE 0
`define CFP_BIT_RAMP_EN 7
`define CFP_BIT_PHASE_EN 6
`define CFP_TEMP_WARN_SET 12'd120
`define CFP_TEMP_WARN_CLR 12'd117
`define CFP_TEMP_FAULT 12'd130
`define CFP_RAMP_ERR_MV 16'd250
`define CFP_OV_MIN_MV 16'd500
`define CFP_OV_ABOVE_MV 16'd250
`define CFP_CLK_HZ 40000000
`define CFP_RETRY_MS 130
`define CFP_PG_DELAY_MAX_MS 150
`endif

//--- design/cfp_delay_timer.v
// Millisecond-based down counter used for restart and power-good delays
`timescale 1ns/1ps
module cfp_delay_timer #(
    parameter CYCLES_PER_MS = 40000,
    parameter MS_WIDTH = 8
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire start,
    input wire [MS_WIDTH-1:0] ms_count,
    output reg done
);
    reg [31:0] tick;
    reg [MS_WIDTH-1:0] remain;
    reg running;
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            tick <= 32'h0;
            remain <= {MS_WIDTH{1'b0}};
            running <= 1'b0;
            done <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            if (start) begin
                tick <= 32'h0;
                remain <= ms_count;
                running <= 1'b1;
            end else if (running) begin
                if (remain == {MS_WIDTH{1'b0}}) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end else if (tick == CYCLES_PER_MS - 1) begin
                    tick <= 32'h0;
                    remain <= remain - 1'b1;
                end else begin
                    tick <= tick + 32'h1;
                end
            end
        end
    end
endmodule

//--- design/cfp_protect.v
// Fault, error and warning manager of a point-of-load converter
`timescale 1ns/1ps
`include "cfp_map.vh"
module cfp_protect #(
    parameter CYCLES_PER_MS = `CFP_CLK_HZ / 1000,
    parameter RETRY_MS = `CFP_RETRY_MS
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire [11:0] temp_c,
    input wire [15:0] vout_mv,
    input wire [15:0] setpoint_mv,
    input wire [15:0] ramp_target_mv,
    input wire [15:0] prebias_mv,
    input wire current_at_limit,
    input wire phase_error,
    input wire ramping_up,
    input wire ramping_down,
    input wire margin_moving,
    input wire steady_state,
    input wire turn_on_cmd,
    input wire input_power_good,
    input wire power_ok_in,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg power_ok_out,
    output reg power_ok_oe,
    output reg fault_line_oe,
    output reg high_switch_on_allowed,
    output reg low_switch_force_on,
    output reg switches_off_now,
    output reg sequenced_off,
    output reg converter_enable,
    output reg temp_comp_enable
);
    localparam ST_OFF = 2'd0;
    localparam ST_RUN = 2'd1;
    localparam ST_HOLD = 2'd2;
    localparam ST_WAIT = 2'd3;

    reg [7:0] protection_config_one;
    reg [7:0] config_two;
    reg [7:0] propagate_mask;
    reg [7:0] protection_status_register;
    reg temp_warning_flag;
    reg [1:0] state;
    reg power_ok_sync1;
    reg power_ok_sync2;
    reg pg_armed;
    reg pg_released;
    reg was_steady;
    reg turn_on_prev;
    reg power_prev;
    reg [5:0] active_fault;
    reg retry_start;
    reg pg_start;
    wire retry_done;
    wire pg_done;
    reg [7:0] pg_delay_ms;
    // Drive history, matches the two-stage pin synchroniser
    reg pg_oe_d1;
    reg pg_oe_d2;
    // Latched restart by clear or turn-off allowed only after one retry period
    reg hold_ready;

    // Percent of a millivolt setpoint, shared by every window limit
    function [15:0] pct_of;
        input [15:0] mv;
        input [7:0] pct;
        reg [23:0] prod;
        reg [23:0] quo;
        begin
            prod = mv * pct;
            quo = prod / 24'd100;
            pct_of = quo[15:0];
        end
    endfunction

    function [15:0] abs_diff;
        input [15:0] a;
        input [15:0] b;
        begin
            abs_diff = (a > b) ? a - b : b - a;
        end
    endfunction

    wire above_prebias = vout_mv > prebias_mv;
    wire [7:0] pg_hi_pct = config_two[5] ? 8'd105 : 8'd110;
    wire [7:0] pg_lo_pct = config_two[4] ? 8'd95 : 8'd90;
    wire [7:0] ov_pct = (config_two[3:2] == 2'd0) ? 8'd110 :
                        (config_two[3:2] == 2'd1) ? 8'd120 : 8'd130;
    wire [7:0] uv_pct = 8'd75 + {3'd0, config_two[1:0], 2'd0} + {5'd0, config_two[1:0], 1'b0}
                        - {6'd0, config_two[1:0]};
    // Limits follow the live setpoint, so margining moves them too
    wire [15:0] pg_hi = pct_of(setpoint_mv, pg_hi_pct);
    wire [15:0] pg_lo = pct_of(setpoint_mv, pg_lo_pct);
    wire [15:0] uv_lim = pct_of(setpoint_mv, uv_pct);
    wire [15:0] ov_pct_lim = pct_of(setpoint_mv, ov_pct);
    wire [15:0] ov_floor = setpoint_mv + `CFP_OV_ABOVE_MV;
    // Clamp to absolute floor and setpoint margin
    wire [15:0] ov_a = (ov_pct_lim < `CFP_OV_MIN_MV) ? `CFP_OV_MIN_MV : ov_pct_lim;
    wire [15:0] ov_lim = (ov_a < ov_floor) ? ov_floor : ov_a;

    wire pg_window_ok = (vout_mv <= pg_hi) && (vout_mv >= pg_lo);
    // Pin reads low after our own drive until the synchroniser catches up
    wire pin_blank = power_ok_oe || pg_oe_d1 || pg_oe_d2;
    // External pull-down reads as a warning
    wire pg_good = pg_window_ok && (power_ok_sync2 || pin_blank);
    wire turn_off_cmd = turn_on_prev && !turn_on_cmd;

    // Fault detection each cycle, current before low voltage
    wire det_current = above_prebias && current_at_limit;
    wire det_low_v = steady_state && (vout_mv < uv_lim) && !det_current;
    wire det_heat = temp_c > `CFP_TEMP_FAULT;
    // No ramp check while margining
    wire det_ramp = protection_config_one[`CFP_BIT_RAMP_EN] && ramping_up && !margin_moving
                    && (abs_diff(vout_mv, ramp_target_mv) > `CFP_RAMP_ERR_MV);
    wire det_high_v = above_prebias && (vout_mv > ov_lim);
    wire det_phase = protection_config_one[`CFP_BIT_PHASE_EN] && phase_error;
    // Order matches bits 5..0 of config one
    wire [5:0] det = {det_ramp, det_heat, det_current, det_low_v, det_high_v, det_phase};
    // Overheat stays asserted until below warning threshold
    wire heat_cond = active_fault[4] ? (temp_c >= `CFP_TEMP_WARN_SET) : det_heat;
    wire [5:0] cond_now = {det_ramp, heat_cond, det_current, det_low_v, det_high_v, det_phase};
    wire [5:0] latched = active_fault & protection_config_one[5:0];
    wire [5:0] status_low = ~protection_status_register[5:0];
    wire [5:0] status_clear = (reg_wr && reg_addr == `CFP_ADDR_STATUS) ? reg_wdata[5:0] : 6'h00;

    cfp_delay_timer #(.CYCLES_PER_MS(CYCLES_PER_MS), .MS_WIDTH(8)) u_retry (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .start(retry_start),
        .ms_count(RETRY_MS[7:0]),
        .done(retry_done)
    );

    cfp_delay_timer #(.CYCLES_PER_MS(CYCLES_PER_MS), .MS_WIDTH(8)) u_pg (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .start(pg_start),
        .ms_count(pg_delay_ms),
        .done(pg_done)
    );

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            protection_config_one <= `CFP_CONFIG_ONE_RESET;
            config_two <= `CFP_CONFIG_TWO_RESET;
            propagate_mask <= `CFP_PROPAGATE_RESET;
            protection_status_register <= 8'h3F;
            temp_warning_flag <= 1'b0;
            state <= ST_OFF;
            power_ok_sync1 <= 1'b1;
            power_ok_sync2 <= 1'b1;
            pg_armed <= 1'b0;
            pg_released <= 1'b0;
            was_steady <= 1'b0;
            turn_on_prev <= 1'b0;
            power_prev <= 1'b0;
            active_fault <= 6'h00;
            retry_start <= 1'b0;
            pg_start <= 1'b0;
            pg_delay_ms <= 8'h00;
            pg_oe_d1 <= 1'b1;
            pg_oe_d2 <= 1'b1;
            hold_ready <= 1'b0;
            reg_rdata <= 8'h00;
            power_ok_out <= 1'b0;
            power_ok_oe <= 1'b1;
            fault_line_oe <= 1'b0;
            high_switch_on_allowed <= 1'b0;
            low_switch_force_on <= 1'b0;
            switches_off_now <= 1'b0;
            sequenced_off <= 1'b0;
            converter_enable <= 1'b0;
            temp_comp_enable <= 1'b1;
        end else if (clk_en) begin
            power_ok_sync1 <= power_ok_in;
            power_ok_sync2 <= power_ok_sync1;
            pg_oe_d1 <= power_ok_oe;
            pg_oe_d2 <= pg_oe_d1;
            turn_on_prev <= turn_on_cmd;
            power_prev <= input_power_good;
            retry_start <= 1'b0;
            pg_start <= 1'b0;
            // Hysteresis on temperature warning, status only
            if (temp_c > `CFP_TEMP_WARN_SET)
                temp_warning_flag <= 1'b1;
            else if (temp_c < `CFP_TEMP_WARN_CLR)
                temp_warning_flag <= 1'b0;
            if (reg_wr && reg_addr == `CFP_ADDR_CONFIG_ONE)
                protection_config_one <= reg_wdata;
            if (reg_wr && reg_addr == `CFP_ADDR_CONFIG_TWO && state != ST_RUN)
                config_two <= reg_wdata;
            if (reg_wr && reg_addr == `CFP_ADDR_PROPAGATE) begin
                propagate_mask <= reg_wdata;
                pg_delay_ms <= (reg_wdata[7:6] == 2'd0) ? 8'd0 : 8'd150;
            end
            temp_comp_enable <= config_two[7] ? 1'b0 : 1'b1;
            // Status bits read zero while a fault is active; host writes one to clear.
            // New detections win over a clearing write in the same cycle
            protection_status_register[7] <= temp_warning_flag;
            // Zero on warning, one while inside window with pin high
            protection_status_register[6] <= pg_armed && pg_released && pg_good;
            // Latched bits stay zero until written one; others return on restart
            protection_status_register[5:0] <= ~det & (protection_status_register[5:0]
                | status_clear | (~active_fault & ~protection_config_one[5:0]));
            if (reg_rd) begin
                case (reg_addr)
                    `CFP_ADDR_STATUS: reg_rdata <= protection_status_register;
                    `CFP_ADDR_CONFIG_ONE: reg_rdata <= protection_config_one;
                    `CFP_ADDR_CONFIG_TWO: reg_rdata <= {2'b00, config_two[5:0]};
                    `CFP_ADDR_PROPAGATE: reg_rdata <= propagate_mask;
                    default: reg_rdata <= 8'h00;
                endcase
            end
            // Power-good armed once steady, released after delay
            was_steady <= steady_state && state == ST_RUN;
            if (steady_state && state == ST_RUN && !was_steady) begin
                pg_armed <= 1'b1;
                pg_released <= 1'b0;
                pg_start <= 1'b1;
            end
            if (pg_done)
                pg_released <= 1'b1;
            // Turn-off drops power-good at command or at ramp-down
            if ((config_two[6] ? ramping_down : turn_off_cmd) || state != ST_RUN) begin
                pg_armed <= 1'b0;
                pg_released <= 1'b0;
            end
            // Pin pulled low outside window
            power_ok_out <= 1'b0;
            // Only the window drives the pin; an outside pull is flagged, not echoed
            power_ok_oe <= !(pg_armed && pg_released && pg_window_ok);
            fault_line_oe <= |(active_fault & propagate_mask[5:0]);
            case (state)
                ST_OFF: begin
                    switches_off_now <= 1'b0;
                    low_switch_force_on <= 1'b0;
                    sequenced_off <= 1'b0;
                    if (turn_on_cmd && input_power_good) begin
                        state <= ST_RUN;
                        converter_enable <= 1'b1;
                        high_switch_on_allowed <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (!turn_on_cmd || !input_power_good) begin
                        state <= ST_OFF;
                        converter_enable <= 1'b0;
                        sequenced_off <= 1'b1;
                    end else if (|det) begin
                        active_fault <= det;
                        hold_ready <= 1'b0;
                        converter_enable <= 1'b0;
                        retry_start <= 1'b1;
                        state <= (|(det & protection_config_one[5:0])) ? ST_HOLD : ST_WAIT;
                        if (det_high_v) begin
                            high_switch_on_allowed <= 1'b0;
                            low_switch_force_on <= 1'b1;
                        end else if (det_ramp || det_current) begin
                            high_switch_on_allowed <= 1'b0;
                            switches_off_now <= 1'b1;
                        end else begin
                            sequenced_off <= 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    // Retry each period until the cause is gone
                    if (active_fault[4] && !(|(cond_now & active_fault))) begin
                        // Overheat restarts as soon as it cools
                        active_fault <= 6'h00;
                        state <= ST_OFF;
                    end else if (retry_done) begin
                        if (|(cond_now & active_fault)) begin
                            retry_start <= 1'b1;
                        end else begin
                            active_fault <= 6'h00;
                            state <= ST_OFF;
                        end
                    end
                end
                ST_HOLD: begin
                    // Latched off until cleared or cycled
                    if (retry_done)
                        hold_ready <= 1'b1;
                    if (!input_power_good && power_prev) begin
                        active_fault <= 6'h00;
                        state <= ST_OFF;
                    end else if (hold_ready) begin
                        if (turn_off_cmd || (!(|(cond_now & active_fault))
                            && (latched & status_low) == 6'h00)) begin
                            active_fault <= 6'h00;
                            state <= ST_OFF;
                        end
                    end
                end
                default: state <= ST_OFF;
            endcase
        end
    end
endmodule

//--- bench/cfp_protect_assertions.sv
// Port checker for the protection block
`timescale 1ns/1ps
module cfp_protect_assertions (
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire [11:0] temp_c,
    input wire [15:0] vout_mv,
    input wire [15:0] setpoint_mv,
    input wire [15:0] prebias_mv,
    input wire current_at_limit,
    input wire input_power_good,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire power_ok_out,
    input wire power_ok_oe,
    input wire high_switch_on_allowed,
    input wire low_switch_force_on,
    input wire switches_off_now,
    input wire sequenced_off,
    input wire converter_enable
);
    // Above every possible overvoltage limit
    wire [31:0] ov_sure = {16'h0000, setpoint_mv} * 3 / 2 + 500;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_oc_fast_off: assert property (
        clk_en && converter_enable && current_at_limit && vout_mv > prebias_mv
        |=> switches_off_now) else $error("overcurrent without fast off");
    a_ov_emergency: assert property (
        clk_en && converter_enable && vout_mv > prebias_mv && vout_mv > ov_sure
        |=> low_switch_force_on && !high_switch_on_allowed) else $error("overvoltage response");
    a_heat_seq_off: assert property (
        clk_en && converter_enable && input_power_good && temp_c > 12'h082
        |=> sequenced_off) else $error("overheat without sequenced off");
    a_unmapped_zero: assert property (
        clk_en && reg_rd && !(reg_addr inside {8'h15, 8'h16, 8'h17, 8'h18})
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !reg_rd |=> $stable(reg_rdata)) else $error("read data moved without read");
    a_pin_drive_low: assert property (
        power_ok_out == 1'b0) else $error("power good pin driven high");
    a_switch_exclusive: assert property (
        !(high_switch_on_allowed && low_switch_force_on)) else $error("both switches on");
    a_reset_state: assert property (disable iff (1'b0)
        sys_rst |=> power_ok_oe && !converter_enable && !low_switch_force_on)
        else $error("reset state wrong");
endmodule

bind cfp_protect cfp_protect_assertions i_cfp_protect_assertions (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .temp_c(temp_c), .vout_mv(vout_mv),
    .setpoint_mv(setpoint_mv), .prebias_mv(prebias_mv), .current_at_limit(current_at_limit),
    .input_power_good(input_power_good), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .power_ok_out(power_ok_out), .power_ok_oe(power_ok_oe),
    .high_switch_on_allowed(high_switch_on_allowed), .low_switch_force_on(low_switch_force_on),
    .switches_off_now(switches_off_now), .sequenced_off(sequenced_off),
    .converter_enable(converter_enable));

//--- bench/cfp_host_model.sv
// Host model issuing single-byte register accesses
`timescale 1ns/1ps
module cfp_host_model (
    input wire sys_clk,
    input wire [7:0] reg_rdata,
    output reg reg_wr = 1'b0,
    output reg reg_rd = 1'b0,
    output reg [7:0] reg_addr = 8'h00,
    output reg [7:0] reg_wdata = 8'h00
);
    task write_reg(input [7:0] addr, input [7:0] data);
        begin
            @(posedge sys_clk);
            reg_wr <= 1'b1;
            reg_addr <= addr;
            reg_wdata <= data;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
            reg_addr <= ~addr;
            reg_wdata <= ~data;
        end
    endtask
    task read_reg(input [7:0] addr, output [7:0] data);
        begin
            @(posedge sys_clk);
            reg_rd <= 1'b1;
            reg_addr <= addr;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            reg_addr <= ~addr;
            #1 data = reg_rdata;
        end
    endtask
endmodule

//--- bench/test_converter_fault_protection.sv
// Self-checking bench for the protection block
`timescale 1ns/1ps
`define CFP_CHECK(what, exp, got) begin checks_done = checks_done + 1; \
    if ((got) !== (exp)) begin mismatches = mismatches + 1; \
    $display("Error %s expected %h seen %h", what, exp, got); end end
module test_converter_fault_protection;
    reg sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, current_at_limit = 1'b0;
    reg phase_error = 1'b0, ramping_up = 1'b0, ramping_down = 1'b0, margin_moving = 1'b0;
    reg steady_state = 1'b1, turn_on_cmd = 1'b1, input_power_good = 1'b1, ext_pull = 1'b0;
    reg [11:0] temp_c = 12'h019;
    reg [15:0] vout_mv = 16'h03E8, setpoint_mv = 16'h03E8, ramp_target_mv = 16'h03E8;
    reg [15:0] prebias_mv = 16'h0000;
    wire reg_wr, reg_rd, power_ok_out, power_ok_oe, fault_line_oe, high_sw, low_sw;
    wire off_now, seq_off, conv_en, power_ok_in;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    integer mismatches = 0, checks_done = 0, cycles = 0, n;
    assign power_ok_in = ~(power_ok_oe | ext_pull);
    always #12.5 sys_clk = ~sys_clk;
    cfp_host_model i_cfp_host_model (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    cfp_protect #(.CYCLES_PER_MS(4), .RETRY_MS(130)) i_cfp_protect (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .clk_en(clk_en), .temp_c(temp_c), .vout_mv(vout_mv),
        .setpoint_mv(setpoint_mv), .ramp_target_mv(ramp_target_mv), .prebias_mv(prebias_mv),
        .current_at_limit(current_at_limit), .phase_error(phase_error),
        .ramping_up(ramping_up), .ramping_down(ramping_down), .margin_moving(margin_moving),
        .steady_state(steady_state), .turn_on_cmd(turn_on_cmd),
        .input_power_good(input_power_good), .power_ok_in(power_ok_in), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .power_ok_out(power_ok_out), .power_ok_oe(power_ok_oe), .fault_line_oe(fault_line_oe),
        .high_switch_on_allowed(high_sw), .low_switch_force_on(low_sw),
        .switches_off_now(off_now), .sequenced_off(seq_off), .converter_enable(conv_en),
        .temp_comp_enable());
    task complete_run;
        begin
            if (mismatches == 0 && checks_done > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            complete_run;
        end
    end
    task do_reset;
        begin
            @(posedge sys_clk) sys_rst <= 1'b1;
            temp_c <= 12'h019;
            vout_mv <= 16'h03E8;
            current_at_limit <= 1'b0;
            ramping_up <= 1'b0;
            steady_state <= 1'b1;
            turn_on_cmd <= 1'b1;
            ext_pull <= 1'b0;
            repeat (6) @(posedge sys_clk);
            sys_rst <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
    endtask
    task chk_reg(input [7:0] addr, input [7:0] mask, input [7:0] exp);
        reg [7:0] v;
        begin
            i_cfp_host_model.read_reg(addr, v);
            `CFP_CHECK("register", exp, v & mask)
        end
    endtask
    task test_regs;
        begin
            do_reset;
            chk_reg(8'h16, 8'hBF, 8'h3F);
            chk_reg(8'h15, 8'hFF, 8'h43);
            chk_reg(8'h40, 8'hFF, 8'h00);
            i_cfp_host_model.write_reg(8'h15, 8'hBC);
            chk_reg(8'h15, 8'hFF, 8'hBC);
        end
    endtask
    task test_temp;
        begin
            @(posedge sys_clk) temp_c <= 12'h079;
            repeat (3) @(posedge sys_clk);
            chk_reg(8'h16, 8'h80, 8'h80);
            `CFP_CHECK("no shutdown", 2'b00, {seq_off, off_now})
            @(posedge sys_clk) temp_c <= 12'h076;
            repeat (3) @(posedge sys_clk);
            chk_reg(8'h16, 8'h80, 8'h80);
            @(posedge sys_clk) temp_c <= 12'h074;
            repeat (3) @(posedge sys_clk);
            chk_reg(8'h16, 8'h80, 8'h00);
        end
    endtask
    task test_overcurrent;
        begin
            do_reset;
            @(posedge sys_clk) current_at_limit <= 1'b1;
            vout_mv <= 16'h01F4;
            repeat (3) @(posedge sys_clk);
            `CFP_CHECK("fast off", 1'b1, off_now)
            chk_reg(8'h16, 8'h0C, 8'h04);
            @(posedge sys_clk) current_at_limit <= 1'b0;
            vout_mv <= 16'h03E8;
            n = 0;
            while (off_now !== 1'b0 && n < 1000) begin
                @(posedge sys_clk);
                n = n + 1;
            end
            `CFP_CHECK("retry time", 1'b1, n > 400 && n < 1000)
        end
    endtask
    task test_overvoltage;
        begin
            do_reset;
            @(posedge sys_clk) vout_mv <= 16'h0898;
            repeat (3) @(posedge sys_clk);
            `CFP_CHECK("switches", 2'b10, {low_sw, high_sw})
            chk_reg(8'h16, 8'h02, 8'h00);
            @(posedge sys_clk) vout_mv <= 16'h03E8;
            repeat (700) @(posedge sys_clk);
            `CFP_CHECK("latched off", 1'b0, conv_en)
            i_cfp_host_model.write_reg(8'h16, 8'h02);
            chk_reg(8'h16, 8'h02, 8'h02);
        end
    endtask
    task test_heat;
        begin
            do_reset;
            @(posedge sys_clk) temp_c <= 12'h083;
            repeat (3) @(posedge sys_clk);
            `CFP_CHECK("sequenced off", 1'b1, seq_off)
            chk_reg(8'h16, 8'h10, 8'h00);
            @(posedge sys_clk) temp_c <= 12'h077;
            n = 0;
            while (seq_off !== 1'b0 && n < 20) begin
                @(posedge sys_clk);
                n = n + 1;
            end
            `CFP_CHECK("heat restart", 1'b1, n < 20)
        end
    endtask
    task test_ramp(input [7:0] cfg, input exp_fault);
        begin
            do_reset;
            i_cfp_host_model.write_reg(8'h15, cfg);
            @(posedge sys_clk) steady_state <= 1'b0;
            ramping_up <= 1'b1;
            vout_mv <= 16'h02BC;
            repeat (3) @(posedge sys_clk);
            `CFP_CHECK("ramp off", exp_fault, off_now)
            chk_reg(8'h16, 8'h20, {2'b00, ~exp_fault, 5'h00});
        end
    endtask
    task test_power_ok;
        begin
            do_reset;
            n = 0;
            while (power_ok_oe !== 1'b0 && n < 100) begin
                @(posedge sys_clk);
                n = n + 1;
            end
            `CFP_CHECK("pin release", 1'b1, n < 100)
            @(posedge sys_clk) vout_mv <= 16'h0352;
            repeat (4) @(posedge sys_clk);
            `CFP_CHECK("pin pulled", 1'b1, power_ok_oe)
            chk_reg(8'h16, 8'h40, 8'h00);
            @(posedge sys_clk) vout_mv <= 16'h03E8;
            repeat (6) @(posedge sys_clk);
            `CFP_CHECK("pin back", 1'b0, power_ok_oe)
            @(posedge sys_clk) ext_pull <= 1'b1;
            repeat (5) @(posedge sys_clk);
            chk_reg(8'h16, 8'h40, 8'h00);
            @(posedge sys_clk) ext_pull <= 1'b0;
            repeat (5) @(posedge sys_clk);
            turn_on_cmd <= 1'b0;
            repeat (3) @(posedge sys_clk);
            `CFP_CHECK("pin at off", 1'b1, power_ok_oe)
        end
    endtask
    initial begin
        test_regs;
        test_temp;
        test_overcurrent;
        test_overvoltage;
        test_heat;
        test_ramp(8'hC3, 1'b1);
        test_ramp(8'h43, 1'b0);
        test_power_ok;
        complete_run;
    end
endmodule
